// ===== rtl/acq_irq_pkg.sv
// package: register map, fields and types of the acquisition interrupt logic
package acq_irq_pkg;
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFS_MASK = 32'h0000_0008;
    localparam logic [31:0] OFS_LATCH = 32'h0000_000C;
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_SWEN_BIT = 1;
    localparam int STAT_EXT_BIT = 0;
    localparam int STAT_EOC_BIT = 1;
    localparam int STAT_LATCH_BIT = 2;
    localparam int EVT_W = 3;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
    localparam logic [2:0] LEVEL_MIN = 3'h2;
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    localparam int NUM_LINES = 6;

    typedef enum logic {
        SRC_EXT,
        SRC_EOC
    } irq_src_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage

// ===== rtl/acq_irq_logic.sv
// design: interrupt source select, latch and host line drive
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - With the external source chosen, each rising edge of the pin sets the latch.
// - With the conversion source chosen, each finished conversion sets the latch.
// - A software-written control bit picks the external or the conversion source.
// - Reset chooses the external edge source.
// - Only the chosen source ever reaches the latch.
// - The request goes out on one host line picked statically from levels 2 to 7.
// - A static disable setting leaves every host line undriven.
// - The latch stays set after the event is gone.
// - The chosen line is asserted only while latch, hardware and software enables hold.
module acq_irq_logic (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire acq_irq_pkg::apb_req_t apb_req,
    output acq_irq_pkg::apb_rsp_t apb_rsp,
    // event sources
    input wire logic ext_irq_or_clock_pin,
    input wire logic conv_done,
    // static board settings
    input wire logic [2:0] irq_level_sel,
    input wire logic hw_irq_enable,
    // host lines, index 0 is level 2
    output logic [acq_irq_pkg::NUM_LINES-1:0] host_irq_out,
    output logic [acq_irq_pkg::NUM_LINES-1:0] host_irq_oe,
    // board interrupt
    output logic irq
);
    import acq_irq_pkg::*;

    logic [1:0] pin_sync;
    logic pin_prev;
    logic [2:0] level_sync;
    logic [2:0] level_q;
    logic [1:0] hwen_sync;
    irq_src_t src;
    logic sw_en;
    logic latch;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;

    // level 2..7 to its one-hot line, zero when no line is wired
    function automatic logic [NUM_LINES-1:0] line_mask(
        input logic [2:0] lvl
    );
        logic [2:0] idx;
        idx = lvl - LEVEL_MIN;
        if (lvl < LEVEL_MIN || lvl > LEVEL_MAX) begin
            return '0;
        end
        return NUM_LINES'(1) << idx;
    endfunction

    // pin is asynchronous; only the second stage is looked at
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync <= 2'h0;
            pin_prev <= 1'b0;
            level_sync <= 3'h0;
            level_q <= 3'h0;
            hwen_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], ext_irq_or_clock_pin};
            pin_prev <= pin_sync[1];
            level_sync <= irq_level_sel;
            level_q <= level_sync;
            hwen_sync <= {hwen_sync[0], hw_irq_enable};
        end
    end

    wire ext_rise = pin_sync[1] & ~pin_prev;
    // conv_done is on sys_clk, a one-cycle pulse per conversion
    wire ext_evt = (src == SRC_EXT) & ext_rise;
    wire eoc_evt = (src == SRC_EOC) & conv_done;
    wire evt = ext_evt | eoc_evt;

    // apb decode, zero wait states
    wire acc = apb_req.psel & apb_req.penable;
    wire wr = acc & apb_req.pwrite;
    wire rd = acc & ~apb_req.pwrite;
    wire hit_ctrl = apb_req.paddr == OFS_CTRL;
    wire hit_stat = apb_req.paddr == OFS_STATUS;
    wire hit_mask = apb_req.paddr == OFS_MASK;
    wire hit_latch = apb_req.paddr == OFS_LATCH;
    wire mapped = hit_ctrl | hit_stat | hit_mask | hit_latch;
    wire clr_latch = wr & hit_latch & apb_req.pwdata[0];
    wire [EVT_W-1:0] stat_clr = {EVT_W{wr & hit_stat}}
        & apb_req.pwdata[EVT_W-1:0];
    wire latch_rise = evt & ~latch;
    wire [EVT_W-1:0] stat_set = {latch_rise, eoc_evt, ext_evt};

    // out-of-range level means no line is driven
    wire level_ok = level_q >= LEVEL_MIN && level_q <= LEVEL_MAX;
    wire drive = hwen_sync[1] & level_ok;
    wire active = latch & hwen_sync[1] & sw_en;
    wire [NUM_LINES-1:0] next_oe = drive
        ? line_mask(level_q) : '0;
    wire [NUM_LINES-1:0] next_out = active ? next_oe : '0;

    wire [31:0] rd_mux = hit_ctrl ? {30'h0, sw_en, src}
        : hit_stat ? {29'h0, status}
        : hit_mask ? {29'h0, mask}
        : hit_latch ? {31'h0, latch} : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= SRC_EXT;
            sw_en <= 1'b0;
            mask <= MASK_RESET;
        end else if (wr & hit_ctrl) begin
            src <= irq_src_t'(apb_req.pwdata[CTRL_SRC_BIT]);
            sw_en <= apb_req.pwdata[CTRL_SWEN_BIT];
        end else if (wr & hit_mask) begin
            mask <= apb_req.pwdata[EVT_W-1:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 1'b0;
            status <= '0;
        end else begin
            latch <= evt | (latch & ~clr_latch);
            status <= stat_set | (status & ~stat_clr);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_irq_out <= '0;
            host_irq_oe <= '0;
            irq <= 1'b0;
            apb_rsp <= '0;
        end else begin
            host_irq_out <= next_out;
            host_irq_oe <= next_oe;
            irq <= |(status & mask);
            apb_rsp.pready <= apb_req.psel & ~apb_req.penable;
            apb_rsp.pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
            apb_rsp.prdata <= (apb_req.psel & ~apb_req.pwrite)
                ? rd_mux : 32'h0;
        end
    end

    // checks: sources and latch
    a_edge_sets_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ext_evt |=> latch
    ) else $error("edge did not set latch");
    a_eoc_sets_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        eoc_evt |=> latch
    ) else $error("eoc did not set latch");
    a_one_source: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(ext_evt && eoc_evt)
    ) else $error("two sources at once");
    a_ext_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        src == SRC_EOC && !conv_done |=> latch == $past(latch && !clr_latch)
    ) else $error("pin reached latch");
    a_eoc_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        src == SRC_EXT && !ext_rise |=> latch == $past(latch && !clr_latch)
    ) else $error("conversion reached latch");
    a_rise_detect: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(pin_sync[1]) |-> ext_rise
    ) else $error("pin edge missed");
    a_edge_once: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ext_rise |=> !ext_rise
    ) else $error("edge seen twice");
    a_latch_sticky: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        latch && !clr_latch |=> latch
    ) else $error("latch dropped");
    a_set_wins: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        evt && clr_latch |=> latch
    ) else $error("clear beat event");
    a_latch_cause: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(latch) |-> $past(evt)
    ) else $error("latch set without event");
    a_clear_release: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clr_latch && !evt |=> !latch ##1 host_irq_out == '0
    ) else $error("line not released");

    // checks: control and reset
    a_src_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr && hit_ctrl |=> src == irq_src_t'($past(apb_req.pwdata[0]))
    ) else $error("source not written");
    a_src_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(wr && hit_ctrl) |=> $stable(src)
    ) else $error("source changed");
    a_swen_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr && hit_ctrl |=> sw_en == $past(apb_req.pwdata[CTRL_SWEN_BIT])
    ) else $error("enable not written");
    a_swen_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(wr && hit_ctrl) |=> $stable(sw_en)
    ) else $error("enable changed");
    a_mask_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr && hit_mask |=> mask == $past(apb_req.pwdata[EVT_W-1:0])
    ) else $error("mask not written");
    a_mask_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(wr && hit_mask) |=> $stable(mask)
    ) else $error("mask changed");
    a_reset_source: assert property (
        @(posedge sys_clk)
        $rose(rst_n) |-> src == SRC_EXT && !sw_en && !latch
    ) else $error("reset state wrong");
    a_reset_quiet: assert property (
        @(posedge sys_clk)
        $rose(rst_n) |-> host_irq_oe == '0 && host_irq_out == '0 && !irq
    ) else $error("outputs busy after reset");

    // checks: host lines
    a_line_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        |host_irq_out |-> $past(latch && sw_en && hwen_sync[1])
    ) else $error("line without cause");
    a_line_no_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !latch |=> host_irq_out == '0
    ) else $error("line without latch");
    a_line_no_swen: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !sw_en |=> host_irq_out == '0
    ) else $error("line without enable");
    a_line_asserted: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        active && drive |=> host_irq_out != '0 && host_irq_out == host_irq_oe
    ) else $error("line not asserted");
    a_single_line: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $onehot0(host_irq_oe)
    ) else $error("more than one line");
    a_out_subset: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (host_irq_out & ~host_irq_oe) == '0
    ) else $error("request on undriven line");
    a_oe_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        hwen_sync[1] |=> host_irq_oe == line_mask($past(level_q))
    ) else $error("wrong line driven");
    a_bad_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !level_ok |=> host_irq_oe == '0
    ) else $error("line for bad level");
    a_hw_disable: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !hwen_sync[1] |=> host_irq_oe == '0
    ) else $error("line driven");

    // checks: status and board interrupt
    a_status_ext: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ext_evt |=> status[STAT_EXT_BIT]
    ) else $error("edge status not set");
    a_status_eoc: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        eoc_evt |=> status[STAT_EOC_BIT]
    ) else $error("eoc status not set");
    a_status_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        latch_rise |=> status[STAT_LATCH_BIT]
    ) else $error("latch status not set");
    a_status_w1c: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wr && hit_stat && apb_req.pwdata[STAT_EXT_BIT] && !ext_evt
            |=> !status[STAT_EXT_BIT]
    ) else $error("status not cleared");
    a_status_sticky: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        status[STAT_LATCH_BIT] && !stat_clr[STAT_LATCH_BIT]
            |=> status[STAT_LATCH_BIT]
    ) else $error("status dropped");
    a_irq_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (status & mask) != '0 |=> irq
    ) else $error("interrupt missing");
    a_irq_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (status & mask) == '0 |=> !irq
    ) else $error("interrupt without cause");

    // checks: register bus, no wait states
    a_setup_ready: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready
    ) else $error("ready missing");
    a_ready_from_setup: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable)
    ) else $error("ready without setup");
    a_idle_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !apb_req.psel |=> !apb_rsp.pready && !apb_rsp.pslverr
    ) else $error("response while idle");
    a_unmapped_err: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !apb_req.penable && !mapped |=> apb_rsp.pslverr
    ) else $error("error missing");
    a_mapped_ok: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        mapped |=> !apb_rsp.pslverr
    ) else $error("error on mapped address");
    a_write_no_data: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && apb_req.pwrite |=> apb_rsp.prdata == 32'h0
    ) else $error("read data on write");
    a_unmapped_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !mapped |=> apb_rsp.prdata == 32'h0
    ) else $error("data from unmapped address");
    a_read_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !apb_req.pwrite && hit_latch
            |=> apb_rsp.prdata == {31'h0, $past(latch)}
    ) else $error("latch read wrong");
    a_read_status: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !apb_req.pwrite && hit_stat
            |=> apb_rsp.prdata == {29'h0, $past(status)}
    ) else $error("status read wrong");
    a_read_ctrl: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apb_req.psel && !apb_req.pwrite && hit_ctrl
            |=> apb_rsp.prdata == {30'h0, $past(sw_en), 1'($past(src))}
    ) else $error("control read wrong");

    c_ext_irq: cover property (@(posedge sys_clk) ext_evt ##2 |host_irq_out);
    c_eoc_irq: cover property (@(posedge sys_clk) eoc_evt ##2 |host_irq_out);
    c_clear: cover property (@(posedge sys_clk) latch ##1 clr_latch);
    c_swen_gate: cover property (@(posedge sys_clk) latch && !sw_en);
    c_bad_level: cover property (@(posedge sys_clk) hwen_sync[1] && !level_ok);
endmodule

// ===== sim/host_irq_model.sv
// host side model: resolves the host interrupt request lines
`timescale 1ns/10ps
module host_irq_model (
    // board drive
    input wire logic [5:0] drv,
    input wire logic [5:0] oe,
    // resolved lines
    output logic [5:0] line
);
    // undriven lines fall to the pull-down level, not the last value
    assign line = drv & oe;
endmodule

// ===== sim/acq_board_interrupt_logic_tb.sv
// bench: random and corner scenarios for the interrupt logic
`timescale 1ns/10ps
module acq_board_interrupt_logic_tb;
    import acq_irq_pkg::*;
    logic sys_clk = 0, rst_n = 0, pin = 0, conv = 0, hwen = 1, err, irq;
    logic [2:0] lvl = 3'h3;
    logic [5:0] hout, hoe, line;
    logic [31:0] rd;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    int fails = 0, n_checks = 0, cyc = 0;
    acq_irq_logic acq_irq_logic_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .apb_req(req), .apb_rsp(rsp), .ext_irq_or_clock_pin(pin),
        .conv_done(conv), .irq_level_sel(lvl), .hw_irq_enable(hwen),
        .host_irq_out(hout), .host_irq_oe(hoe), .irq(irq));
    host_irq_model host_irq_model_inst (.drv(hout), .oe(hoe), .line(line));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        // about nineteen times the length of the whole sequence (about 210 cycles)
        if (cyc == 4000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // edge first, so a release never meets the next setup in one step
    task automatic apb(input logic wr, input logic [31:0] a,
        input logic [31:0] wd);
        @(posedge sys_clk);
        req <= '{a, 1'b1, 1'b0, wr, wd};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // one event; pin held long enough for its synchroniser
    task automatic ev(input logic conv_src);
        @(posedge sys_clk);
        if (conv_src)
            conv <= 1'b1;
        else
            pin <= 1'b1; // pin used as an event, never as a clock
        @(posedge sys_clk);
        conv <= 1'b0;
        tick(3);
        pin <= 1'b0;
        tick(5);
    endtask
    function automatic logic [5:0] sel(logic [2:0] l, logic en);
        if (en && l >= LEVEL_MIN && l <= LEVEL_MAX)
            return 6'h1 << (l - LEVEL_MIN);
        return 6'h0;
    endfunction
    initial begin
        void'($urandom(32'h12E43D81));
        tick(16);
        rst_n <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, {30'h0, CTRL_RESET});
        apb(1'b1, OFS_MASK, 32'h4);
        apb(1'b1, 32'h10, 32'hF);
        check(err, 1'b1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFS_CTRL, {30'h0, 1'b1, s[0]});
            ev(!s[0]);
            apb(1'b0, OFS_LATCH, 32'h0);
            check(rd, 32'h0);
            check(line, 6'h0);
            ev(s[0]);
            check(line, sel(lvl, hwen));
            check(irq, 1'b1);
            apb(1'b1, OFS_LATCH, 32'h1);
            apb(1'b1, OFS_STATUS, 32'h7);
            tick(2);
            check(line, 6'h0);
            check(irq, 1'b0);
        end
        apb(1'b1, OFS_CTRL, 32'h0);
        ev(1'b0);
        check(line, 6'h0);
        apb(1'b1, OFS_CTRL, 32'h2);
        // every level with the enable on, then every level again with the enable off or random
        for (int i = 0; i < 16; i++) begin
            lvl <= i[2:0];
            hwen <= !i[3] || (i[0] && 1'($urandom));
            tick(6);
            check(hoe, sel(lvl, hwen));
            check(line, sel(lvl, hwen));
        end
        apb(1'b1, OFS_MASK, 32'h0);
        tick(2);
        check(irq, 1'b0);
        conclude();
    end
endmodule
